// [adc_serial_port.sv]
// Serial command and result port of the eight-input converter, with an APB status window.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module adc_serial_port
   import adc_port_pkg::*;
(
   input  wire logic           clk_sys,
   input  wire logic           rst_n,
   input  wire logic [7:0]     paddr,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [31:0]    pwdata,
   output logic [31:0]         prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire logic           select_and_shutdown_pin_n,
   input  wire logic           serial_clock,
   input  wire logic           serial_data_in,
   output logic                serial_data_out,
   output logic                serial_data_out_en,
   input  wire level_bank_type analog_inputs_zero_to_seven,
   input  wire level_type      reference_level
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic reg_sel_type decode_addr(input logic [PADDR_W-1:0] addr);
      reg_sel_type sel;
      begin
         case (addr)
            CTRL_OFFSET:   sel = REG_CTRL;
            STATUS_OFFSET: sel = REG_STATUS;
            RESULT_OFFSET: sel = REG_RESULT;
            CONFIG_OFFSET: sel = REG_CONFIG;
            COUNT_OFFSET:  sel = REG_COUNT;
            default:       sel = REG_NONE;
         endcase
         return sel;
      end
   endfunction

   function automatic logic [4:0] sat_inc(input logic [4:0] value);
      begin
         return (value == FALL_SATURATE) ? value : value + 5'h01;
      end
   endfunction

   // A transaction is open from the start bit until select rises.
   function automatic logic in_transaction(input phase_type ph);
      begin
         return (ph == PH_COMMAND) || (ph == PH_CONVERT);
      end
   endfunction

   // The tail repeats bits one to nine, so bit zero goes out only once.
   function automatic logic tail_bit(input code_type code, input logic [4:0] fall_cnt);
      logic [4:0] offset;
      begin
         offset = fall_cnt - FALL_LSB;
         return code[offset[3:0]];
      end
   endfunction

   // Status bits are packed in one place, so each bit position stays beside
   // its meaning rather than inside the bus decoder.
   function automatic logic [31:0] status_word(input state_type s);
      logic [31:0] word;
      begin
         word                    = '0;
         word[STAT_STANDBY_BIT]  = (s.phase == PH_STANDBY);
         word[STAT_DONE_BIT]     = s.done;
         word[STAT_BUSY_BIT]     = in_transaction(s.phase);
         word[STAT_ARMED_BIT]    = s.armed;
         word[STAT_SAMPLING_BIT] = s.sampling;
         return word;
      end
   endfunction

   // ****************************************************************
   // State and submodules
   // ****************************************************************
   state_type   s_reg;
   state_type   s_next;
   logic        sclk_rise;
   logic        sclk_fall;
   logic        take_bit;
   code_type    decided_code;
   code_type    trial;
   level_type   mux_pos;
   level_type   mux_neg;
   reg_sel_type rd_sel;
   reg_sel_type wr_sel;
   logic        apb_setup;
   logic        apb_write;
   logic        done_set;
   logic        done_clear;
   logic        select_low;

   // Edges are a plain compare with the last sample, seen in the clock where the pin moves,
   // so every serial level must last at least one system clock to be seen.
   serial_edge_detect u_edge
   (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .level   (serial_clock),
      .rise    (sclk_rise),
      .fall    (sclk_fall)
   );

   assign trial = s_reg.code | s_reg.bit_mask;

   // The code after this step's decision: the trial bit is kept or dropped.
   assign decided_code = take_bit ? trial : s_reg.code;

   // A zero reference lets every trial pass, so the code then pins at all ones.
   sar_compare u_sar
   (
      .hold_pos        (s_reg.hold_pos),
      .hold_neg        (s_reg.hold_neg),
      .reference_level (reference_level),
      .trial           (trial),
      .take_bit        (take_bit)
   );

   // ****************************************************************
   // Input selection
   // ****************************************************************
   // Pair mode: the channel code names the positive member, its neighbour
   // in the same pair is the negative one.
   always_comb
   begin
      mux_pos = analog_inputs_zero_to_seven[s_reg.chan];
      if (s_reg.single)
         mux_neg = '0;
      else
         mux_neg = analog_inputs_zero_to_seven[s_reg.chan ^ 3'h1];
   end

   assign select_low = ~select_and_shutdown_pin_n;
   assign apb_setup  = psel & ~penable;
   assign apb_write  = psel & penable & pwrite;
   assign rd_sel     = decode_addr(paddr);
   assign wr_sel     = decode_addr(paddr);

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   always_comb
   begin
      s_next     = s_reg;
      done_set   = 1'b0;
      done_clear = 1'b0;

      if (!select_low)
      begin
         // Standby: output floats and the parse restarts on the next select.
         // A cut after the last result bit is not an abort: the tail is optional.
         if (in_transaction(s_reg.phase) && s_reg.fall_cnt <= FALL_LSB)
            s_next.abort_count = s_reg.abort_count + 16'h0001;
         s_next.phase    = PH_STANDBY;
         s_next.armed    = 1'b1;
         s_next.rise_cnt = '0;
         s_next.fall_cnt = '0;
         s_next.sampling = 1'b0;
         s_next.dout     = 1'b0;
         s_next.dout_en  = 1'b0;
      end
      else
      begin
         case (s_reg.phase)
            PH_STANDBY:
            begin
               // A part that wakes with select already low waits for a high.
               if (s_reg.armed && !s_reg.port_disable)
                  s_next.phase = PH_HUNT;
            end
            PH_HUNT:
            begin
               // Low data bits seen here are leading zeros and pass by.
               if (sclk_rise && serial_data_in)
               begin
                  s_next.phase    = PH_COMMAND;
                  s_next.rise_cnt = '0;
                  s_next.fall_cnt = '0;
               end
            end
            PH_COMMAND:
            begin
               // Rises count from the start bit; the fourth closes the command.
               if (sclk_rise)
               begin
                  s_next.rise_cnt = s_reg.rise_cnt + 3'h1;
                  case (s_reg.rise_cnt + 3'h1)
                     RISE_SGL:     s_next.single  = serial_data_in;
                     RISE_CH_HIGH: s_next.chan[2] = serial_data_in;
                     RISE_CH_MID:  s_next.chan[1] = serial_data_in;
                     RISE_CH_LOW:
                     begin
                        s_next.chan[0]  = serial_data_in;
                        s_next.sampling = 1'b1;
                        s_next.phase    = PH_CONVERT;
                     end
                     default:      s_next.rise_cnt = s_reg.rise_cnt;
                  endcase
               end
               if (sclk_fall)
                  s_next.fall_cnt = sat_inc(s_reg.fall_cnt);
            end
            PH_CONVERT:
            begin
               // Every step below waits on a master clock edge.
               if (sclk_fall)
               begin
                  s_next.fall_cnt = sat_inc(s_reg.fall_cnt);
                  if (s_reg.fall_cnt == FALL_SAMPLE_END)
                  begin
                     // Half a period after the fifth rise closes the window.
                     s_next.sampling = 1'b0;
                     s_next.code     = '0;
                     s_next.bit_mask = CODE_MSB_MASK;
                     s_next.dout     = 1'b0;
                     s_next.dout_en  = 1'b1;
                  end
                  else if (s_reg.fall_cnt == FALL_NULL)
                     s_next.dout = 1'b0;
                  else if (s_reg.fall_cnt >= FALL_MSB && s_reg.fall_cnt <= FALL_LSB)
                  begin
                     // One decision per falling edge, shipped as it is made.
                     s_next.dout     = take_bit;
                     s_next.code     = decided_code;
                     s_next.bit_mask = s_reg.bit_mask >> 1;
                     if (s_reg.fall_cnt == FALL_LSB)
                     begin
                        done_set           = 1'b1;
                        s_next.last_result = decided_code;
                        s_next.last_cfg    = {s_reg.single, s_reg.chan};
                        s_next.conv_count  = s_reg.conv_count + 16'h0001;
                     end
                  end
                  else if (s_reg.fall_cnt > FALL_LSB && s_reg.fall_cnt <= FALL_REV_LAST)
                     s_next.dout = tail_bit(s_reg.code, s_reg.fall_cnt);
                  else
                     s_next.dout = 1'b0;
               end
               // No return to the hunt while select stays low: one conversion per select.
            end
            default:
               s_next.phase = PH_STANDBY;
         endcase
      end

      // ****************************************************************
      // Hold capacitor
      // ****************************************************************
      // Track the chosen input only while the window is open, then hold it.
      if (s_reg.sampling)
      begin
         s_next.hold_pos = mux_pos;
         s_next.hold_neg = mux_neg;
      end

      // ****************************************************************
      // APB slave
      // ****************************************************************
      // Read data is latched in the setup cycle, so the access cycle answers at once.
      if (apb_setup)
      begin
         s_next.pslverr = (rd_sel == REG_NONE);
         s_next.prdata  = '0;
         case (rd_sel)
            REG_CTRL:
               s_next.prdata[CTRL_DISABLE_BIT] = s_reg.port_disable;
            REG_STATUS:
               s_next.prdata = status_word(s_reg);
            REG_RESULT:
               s_next.prdata[RESULT_W-1:0] = s_reg.last_result;
            REG_CONFIG:
               s_next.prdata[3:0] = s_reg.last_cfg;
            REG_COUNT:
               s_next.prdata = {s_reg.abort_count, s_reg.conv_count};
            default:
               s_next.prdata = '0;
         endcase
      end

      if (apb_write)
      begin
         case (wr_sel)
            REG_CTRL:   s_next.port_disable = pwdata[CTRL_DISABLE_BIT];
            REG_STATUS: done_clear = pwdata[STAT_DONE_BIT];
            // Other addresses leave the state untouched.
            default:    s_next.port_disable = s_reg.port_disable;
         endcase
      end

      // ****************************************************************
      // Completion flag
      // ****************************************************************
      // A completion in the clearing cycle survives the clear.
      s_next.done = done_set | (s_reg.done & ~done_clear);
   end

   // ****************************************************************
   // State register and outputs
   // ****************************************************************
   // The part wakes unarmed: select must be seen high once before a frame opens.
   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         s_reg <= STATE_RESET;
      else
         s_reg <= s_next;
   end

   // Every register answers in the first access cycle, with no wait states.
   assign pready             = psel & penable;
   assign prdata             = s_reg.prdata;
   assign pslverr            = s_reg.pslverr;
   assign serial_data_out    = s_reg.dout;
   assign serial_data_out_en = s_reg.dout_en;

endmodule

// [adc_port_pkg.sv]
// Shared constants, field layouts and state types of the converter serial command port.
package adc_port_pkg;

   // ****************************************************************
   // Widths
   // ****************************************************************
   localparam int SAMPLE_W   = 16;
   localparam int RESULT_W   = 10;
   localparam int CH_COUNT   = 8;
   localparam int CODE_SHIFT = 10;
   localparam int PADDR_W    = 8;

   typedef logic [SAMPLE_W-1:0]              level_type;
   typedef logic [CH_COUNT-1:0][SAMPLE_W-1:0] level_bank_type;
   typedef logic [RESULT_W-1:0]              code_type;

   // ****************************************************************
   // Serial sequence positions, counted from the start bit
   // ****************************************************************
   localparam logic [2:0] RISE_SGL      = 3'h1;
   localparam logic [2:0] RISE_CH_HIGH  = 3'h2;
   localparam logic [2:0] RISE_CH_MID   = 3'h3;
   localparam logic [2:0] RISE_CH_LOW   = 3'h4;
   localparam logic [4:0] FALL_SAMPLE_END = 5'h05;
   localparam logic [4:0] FALL_NULL       = 5'h06;
   localparam logic [4:0] FALL_MSB        = 5'h07;
   localparam logic [4:0] FALL_LSB        = 5'h10;
   localparam logic [4:0] FALL_REV_LAST   = 5'h19;
   localparam logic [4:0] FALL_SATURATE   = 5'h1f;
   localparam code_type   CODE_MSB_MASK   = 10'h200;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [PADDR_W-1:0] CTRL_OFFSET   = 8'h00;
   localparam logic [PADDR_W-1:0] STATUS_OFFSET = 8'h04;
   localparam logic [PADDR_W-1:0] RESULT_OFFSET = 8'h08;
   localparam logic [PADDR_W-1:0] CONFIG_OFFSET = 8'h0c;
   localparam logic [PADDR_W-1:0] COUNT_OFFSET  = 8'h10;
   localparam int CTRL_DISABLE_BIT  = 0;
   localparam int STAT_STANDBY_BIT  = 0;
   localparam int STAT_DONE_BIT     = 1;
   localparam int STAT_BUSY_BIT     = 2;
   localparam int STAT_ARMED_BIT    = 3;
   localparam int STAT_SAMPLING_BIT = 4;

   typedef enum logic [2:0] {REG_CTRL, REG_STATUS, REG_RESULT, REG_CONFIG, REG_COUNT,
                             REG_NONE} reg_sel_type;

   typedef enum logic [1:0] {PH_STANDBY, PH_HUNT, PH_COMMAND, PH_CONVERT} phase_type;

   typedef struct packed {
      phase_type   phase;
      logic        armed;
      logic [2:0]  rise_cnt;
      logic [4:0]  fall_cnt;
      logic        single;
      logic [2:0]  chan;
      logic        sampling;
      level_type   hold_pos;
      level_type   hold_neg;
      code_type    code;
      code_type    bit_mask;
      logic        dout;
      logic        dout_en;
      logic        port_disable;
      logic        done;
      code_type    last_result;
      logic [3:0]  last_cfg;
      logic [15:0] conv_count;
      logic [15:0] abort_count;
      logic [31:0] prdata;
      logic        pslverr;
   } state_type;

   localparam state_type STATE_RESET = state_type'(0);

   typedef struct packed {
      logic prev;
   } edge_state_type;

   localparam edge_state_type EDGE_RESET = edge_state_type'(0);

endpackage

// [serial_edge_detect.sv]
// Rise and fall detector for the serial clock pin, sampled on the system clock.
`timescale 1ns/1ps
module serial_edge_detect
   import adc_port_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic level,
   output logic      rise,
   output logic      fall
);

   edge_state_type s_reg;
   edge_state_type s_next;

   always_comb
   begin
      s_next      = s_reg;
      s_next.prev = level;
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         s_reg <= EDGE_RESET;
      else
         s_reg <= s_next;
   end

   // The pin is taken as synchronous, so the edges are a plain compare.
   assign rise = level & ~s_reg.prev;
   assign fall = ~level & s_reg.prev;

endmodule

// [sar_compare.sv]
// One successive-approximation decision on the held input against a trial code.
`timescale 1ns/1ps
module sar_compare
   import adc_port_pkg::*;
(
   input  wire level_type hold_pos,
   input  wire level_type hold_neg,
   input  wire level_type reference_level,
   input  wire code_type  trial,
   output logic           take_bit
);

   localparam int PROD_W = SAMPLE_W + CODE_SHIFT;

   logic [SAMPLE_W-1:0] diff;
   logic [PROD_W-1:0]   scaled_in;
   logic [PROD_W-1:0]   scaled_trial;

   always_comb
   begin
      // A positive input at or below the negative one reads as zero volts.
      diff         = (hold_pos > hold_neg) ? hold_pos - hold_neg : '0;
      scaled_in    = {diff, {CODE_SHIFT{1'b0}}};
      scaled_trial = PROD_W'(trial) * PROD_W'(reference_level);
      // Code is input times 1024 over reference, so the full scale pins at all ones.
      take_bit     = scaled_in >= scaled_trial;
   end

endmodule

// [adc_port_monitor.sv]
// Concurrent checks on the serial pins and the APB answer of the converter port.
`timescale 1ns/1ps
module adc_port_monitor
(
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [7:0]  paddr,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   input wire logic        select_and_shutdown_pin_n,
   input wire logic        serial_clock,
   input wire logic        serial_data_out,
   input wire logic        serial_data_out_en
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence s_null_run;
      !serial_data_out [*8];
   endsequence
   property p_ready_now;
      pready == (psel && penable);
   endproperty
   a_ready_now: assert property (p_ready_now)
      else $error("pready differs from psel and penable");
   property p_bad_addr;
      psel && !penable && paddr > 8'h10 |=> pslverr && prdata == 32'h0;
   endproperty
   a_bad_addr: assert property (p_bad_addr)
      else $error("unmapped access not refused");
   property p_en_off;
      select_and_shutdown_pin_n [*3] |-> !serial_data_out_en;
   endproperty
   a_en_off: assert property (p_en_off)
      else $error("output still enabled in standby");
   property p_dout_fall;
      $changed(serial_data_out) && $past(serial_data_out_en)
         |-> !serial_clock && !$past(serial_clock);
   endproperty
   a_dout_fall: assert property (p_dout_fall)
      else $error("result bit changed away from a falling edge");
   property p_en_rise;
      $rose(serial_data_out_en) |-> !serial_clock && !select_and_shutdown_pin_n;
   endproperty
   a_en_rise: assert property (p_en_rise)
      else $error("output enabled outside a selected falling edge");
   property p_null;
      $rose(serial_data_out_en) |-> s_null_run;
   endproperty
   a_null: assert property (p_null)
      else $error("null bit not low");
   property p_en_hold;
      serial_data_out_en && !select_and_shutdown_pin_n |=> serial_data_out_en;
   endproperty
   a_en_hold: assert property (p_en_hold)
      else $error("output enable dropped while selected");
   property p_dout_off;
      !serial_data_out_en && !$past(serial_data_out_en) |-> !serial_data_out;
   endproperty
   a_dout_off: assert property (p_dout_off)
      else $error("result bit high while output disabled");
endmodule
bind adc_serial_port adc_port_monitor i_adc_port_monitor
(
   .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .select_and_shutdown_pin_n(select_and_shutdown_pin_n), .serial_clock(serial_clock),
   .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en)
);

// [spi_master_model.sv]
// Serial master model that frames commands and collects the result stream.
`timescale 1ns/1ps
module spi_master_model
(
   input  wire logic   clk_sys,
   input  wire logic   serial_data_out,
   input  wire logic   serial_data_out_en,
   output logic        select_n,
   output logic        sclk,
   output logic        mosi,
   output logic [31:0] rx,
   output logic        en_seen
);
   initial
   begin
      select_n = 1'b1;
      sclk = 1'b0;
      mosi = 1'b0;
   end
   // Bit j of rx is the result line seen at the j-th rise after the start bit.
   // Clock idles low between frames; the data line toggles there so nothing stale lingers.
   task automatic frame(input logic [3:0] cfg, input int nclk, input int half);
      logic [5:0] cmd;
      cmd = {2'b01, cfg};
      rx = 32'h0;
      en_seen = 1'b0;
      @(posedge clk_sys);
      select_n <= 1'b0;
      repeat (2) @(posedge clk_sys);
      for (int i = 0; i < nclk; i++)
      begin
         mosi <= (i < 6) ? cmd[5-i] : ~mosi;
         repeat (2) @(posedge clk_sys);
         sclk <= 1'b1;
         if (i > 0)
            rx[i-1] = serial_data_out;
         en_seen = en_seen | serial_data_out_en;
         repeat (half) @(posedge clk_sys);
         sclk <= 1'b0;
         repeat (half) @(posedge clk_sys);
      end
      select_n <= 1'b1;
      mosi <= ~mosi;
      repeat (4) @(posedge clk_sys);
   endtask
endmodule

// [tb.sv]
// Self-checking bench of the converter serial command port.
`timescale 1ns/1ps
module tb import adc_port_pkg::*; ;
   logic           clk_sys;
   logic           rst_n = 1'b0;
   logic [7:0]     paddr = 8'h00;
   logic           psel = 1'b0;
   logic           penable = 1'b0;
   logic           pwrite = 1'b0;
   logic [31:0]    pwdata = 32'h0;
   logic [31:0]    prdata, rd, rx;
   logic           pready, pslverr, err, cs_n, sclk, din, dout, dout_en, en_seen;
   level_bank_type levels = {16'h0321, 16'h0abc, 16'h1000, 16'h0004,
                             16'h1000, 16'h0ffc, 16'h0100, 16'h0800};
   level_type      ref_lvl = 16'h1000;
   int             error_cnt = 0;
   int             checks = 0;
   localparam logic [31:0] IDLE_STATUS = (32'h1 << STAT_STANDBY_BIT) |
                                         (32'h1 << STAT_ARMED_BIT);
   localparam logic [31:0] DONE_STATUS = IDLE_STATUS | (32'h1 << STAT_DONE_BIT);
   // Each row: command bits {single, channel} beside the code they must give.
   logic [13:0]    rows [16] = '{{4'h8, 10'h200}, {4'h9, 10'h040}, {4'ha, 10'h3ff},
      {4'hb, 10'h3ff}, {4'hc, 10'h001}, {4'hd, 10'h3ff}, {4'he, 10'h2af},
      {4'hf, 10'h0c8}, {4'h0, 10'h1c0}, {4'h1, 10'h000}, {4'h2, 10'h000},
      {4'h3, 10'h001}, {4'h4, 10'h000}, {4'h5, 10'h3ff}, {4'h6, 10'h1e6},
      {4'h7, 10'h000}};
   adc_serial_port i_adc_serial_port
   (
      .clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .select_and_shutdown_pin_n(cs_n), .serial_clock(sclk),
      .serial_data_in(din), .serial_data_out(dout), .serial_data_out_en(dout_en),
      .analog_inputs_zero_to_seven(levels), .reference_level(ref_lvl)
   );
   spi_master_model i_spi_master_model
   (
      .clk_sys(clk_sys), .serial_data_out(dout), .serial_data_out_en(dout_en),
      .select_n(cs_n), .sclk(sclk), .mosi(din), .rx(rx), .en_seen(en_seen)
   );
   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [31:0] stream(input code_type c);
      stream = 32'h0;
      for (int b = 0; b < 10; b++)
      begin
         stream[17-b] = c[b];
         if (b > 0)
            stream[17+b] = c[b];
      end
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp)
      begin
         $display("BAD %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // ****************************************
   // Clock, watchdog and test sequence
   // ****************************************
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   initial
   begin
      #200000;
      error_cnt++;
      stop_test();
   end
   initial
   begin
      repeat (8) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int k = 0; k < 5; k++)
      begin
         apb(1'b0, 8'(k * 4), 32'h0);
         chk("reset value", (k == 1) ? IDLE_STATUS : 32'h0, rd);
      end
      chk("reset enable", 32'h0, {31'h0, dout_en});
      $display("test reset done");
      for (int r = 0; r < 16; r++)
      begin
         i_spi_master_model.frame(rows[r][13:10], 30, (r % 2) ? 9 : 4);
         chk("stream", stream(rows[r][9:0]), rx);
         chk("enabled", 32'h1, {31'h0, en_seen});
         apb(1'b0, RESULT_OFFSET, 32'h0);
         chk("result", {22'h0, rows[r][9:0]}, rd);
         apb(1'b0, CONFIG_OFFSET, 32'h0);
         chk("config", {28'h0, rows[r][13:10]}, rd);
      end
      $display("test table done");
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("status done", DONE_STATUS, rd);
      apb(1'b1, STATUS_OFFSET, 32'h1 << STAT_DONE_BIT);
      apb(1'b0, STATUS_OFFSET, 32'h0);
      chk("status cleared", IDLE_STATUS, rd);
      $display("test status done");
      i_spi_master_model.frame(4'h8, 12, 4);
      chk("abort stream", stream(10'h200) & 32'h7ff, rx);
      chk("abort enable", 32'h0, {31'h0, dout_en});
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk("abort count", 32'h0001_0010, rd);
      apb(1'b0, RESULT_OFFSET, 32'h0);
      chk("abort result", 32'h0, rd);
      i_spi_master_model.frame(4'h9, 30, 4);
      chk("restart stream", stream(10'h040), rx);
      $display("test abort done");
      apb(1'b1, CTRL_OFFSET, 32'h1);
      apb(1'b0, CTRL_OFFSET, 32'h0);
      chk("disable bit", 32'h1, rd);
      i_spi_master_model.frame(4'h8, 30, 4);
      chk("disabled stream", 32'h0, rx);
      chk("disabled enable", 32'h0, {31'h0, en_seen});
      apb(1'b0, COUNT_OFFSET, 32'h0);
      chk("disabled count", 32'h0001_0011, rd);
      apb(1'b1, CTRL_OFFSET, 32'h0);
      $display("test disable done");
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped error", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      $display("test unmapped done");
      stop_test();
   end
endmodule
